// [core/fdc_pos_map.svh]
// Purpose: constants for the head positioning command interpreter
// Assumes: AHB-Lite word registers, 100 MHz clock
// Notes:   offsets are byte addresses
`ifndef FDC_POS_MAP_SVH
`define FDC_POS_MAP_SVH
// ************************************************************
// register offsets
// ************************************************************
`define OFF_CMD      8'h00
`define OFF_RESULT   8'h04
`define OFF_STATUS   8'h08
`define OFF_INTSTAT  8'h0C
`define OFF_INTMASK  8'h10
// ************************************************************
// status register fields
// ************************************************************
`define ST_RQM_BIT   0
`define ST_DIO_BIT   1
`define ST_BUSY_BIT  2
`define ST_CNT_LSB   4
// ************************************************************
// interrupt status bits
// ************************************************************
`define INT_SEEK_BIT 0
`define INT_RES_BIT  1
// ************************************************************
// command codes and values
// ************************************************************
`define CMD_RECAL    8'h07
`define CMD_SENSEI   8'h08
`define CMD_SPECIFY  8'h03
`define CMD_SEEK     8'h0F
`define CMD_CONFIG   8'h13
`define CMD_DUMPREG  8'h0E
`define CMD_PERP     8'h12
`define CMD_LOCK     8'h14
`define CMD_SENSED   8'h04
`define CMD_VERSION  8'h10
`define CMD_RELSEEK  8'h8F
`define VAL_INVALID  8'h80
`define VAL_VERSION  8'h90
`define VAL_SEEKEND  8'h20
// ************************************************************
// reset values and timing
// ************************************************************
`define RST_CONFIG   8'h20
`define RST_SPEC1    8'h00
`define RST_SPEC2    8'h00
`define STEP_NS      3000
`define STEP_CYC     (`STEP_NS / 10)
`endif

// [core/fdc_pos_pkg.sv]
// Purpose: types for the head positioning command interpreter
// Assumes: nothing
// Notes:   numeric constants live in fdc_pos_map.svh
package fdc_pos_pkg;
  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_PARAM  = 3'b001,
    PH_EXEC   = 3'b010,
    PH_RESULT = 3'b011
  } phase_t;
endpackage : fdc_pos_pkg

// [core/head_stepper.sv]
// Purpose: steps one head toward a target cylinder
// Assumes: start is a single-cycle pulse while idle
// Notes:   recalibrate seeks to 0 and ends when track 0 is seen or after 255 steps
`timescale 1ns/1ps
`include "fdc_pos_map.svh"
module head_stepper (
  input  wire logic       clk,        // controller clock
  input  wire logic       sys_rst,    // sync reset, high
  input  wire logic       start,      // begin motion
  input  wire logic       recal,      // seek track 0 by sensor
  input  wire logic [7:0] fromCyl,    // present cylinder
  input  wire logic [7:0] toCyl,      // target cylinder
  input  wire logic       track0,     // synchronised track 0
  output logic            stepPulse,  // one step strobe
  output logic            stepOut,    // direction outward
  output logic            done        // motion finished pulse
);
  logic [15:0] timer;
  logic [7:0]  cur;
  logic [7:0]  left;
  logic        active;
  // ************************************************************
  // step sequencer
  // ************************************************************
  // the timer paces steps so the mechanism can settle
  always_ff @(posedge clk) begin
    stepPulse <= 1'b0;
    done      <= 1'b0;
    if (sys_rst) begin
      active  <= 1'b0;
      timer   <= 16'h0000;
      cur     <= 8'h00;
      left    <= 8'h00;
      stepOut <= 1'b0;
    end else if (start) begin
      active  <= 1'b1;
      timer   <= 16'h0000;
      cur     <= fromCyl;
      left    <= 8'hFF;
      stepOut <= recal || (toCyl < fromCyl);
    end else if (active) begin
      if (timer != 16'h0000) begin
        timer <= timer - 16'h0001;
      end else if (recal ? (track0 || left == 8'h00) : (cur == toCyl)) begin
        active <= 1'b0;
        done   <= 1'b1;
      end else begin
        stepPulse <= 1'b1;
        timer     <= 16'(`STEP_CYC);
        left      <= left - 8'h01;
        cur       <= stepOut ? cur - 8'h01 : cur + 8'h01;
      end
    end
  end
endmodule : head_stepper

// [core/fdc_head_positioning_commands.sv]
// Purpose: non-data command interpreter of a floppy controller
// Assumes: host writes command bytes, reads result bytes over AHB-Lite
// Notes:   one positioning operation runs at a time
// Operation
// - recalibrate steps head out to track zero
// - sense interrupt returns status zero then cylinder, or 80H alone when nothing is pending
// - sense interrupt reports last finished positioning
// - seek steps head to new cylinder target
// - register dump returns ten bytes in order
// - sense drive status returns drive status word
// - undefined code returns single byte 80H
`timescale 1ns/1ps
`include "fdc_pos_map.svh"
module fdc_head_positioning_commands
  import fdc_pos_pkg::*;
(
  input  wire logic        clk,         // controller clock
  input  wire logic        sys_rst,     // sync reset, high
  input  wire logic        hsel,        // slave select
  input  wire logic [31:0] haddr,       // byte address
  input  wire logic [1:0]  htrans,      // transfer type
  input  wire logic        hwrite,      // write access
  input  wire logic [2:0]  hsize,       // transfer size
  input  wire logic        hready,      // bus ready in
  input  wire logic [31:0] hwdata,      // write data
  output logic      [31:0] hrdata,      // read data
  output logic             hreadyout,   // slave ready
  output logic             hresp,       // always okay
  input  wire logic [3:0]  track0Pin,   // track 0 per drive
  input  wire logic [3:0]  protectPin,  // write protect per drive
  input  wire logic [3:0]  readyPin,    // drive ready per drive
  input  wire logic [3:0]  twoSidePin,  // two sided per drive
  output logic      [1:0]  driveSel,    // selected drive
  output logic             headSel,     // head select
  output logic             stepPulse,   // step strobe
  output logic             stepDir,     // high = outward
  output logic             irq          // interrupt level
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [15:0] pinMeta;
  logic [15:0] pinSync;
  always_ff @(posedge clk) begin
    pinMeta <= {twoSidePin, readyPin, protectPin, track0Pin};
    pinSync <= pinMeta;
  end
  // ************************************************************
  // bus slave address phase capture
  // ************************************************************
  logic       pendWr;
  logic       pendRd;
  logic [7:0] pendAddr;
  logic       busTake;
  assign busTake = hsel && hready && htrans[1];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pendWr   <= 1'b0;
      pendRd   <= 1'b0;
      pendAddr <= 8'h00;
    end else begin
      pendWr   <= busTake && hwrite;
      pendRd   <= busTake && !hwrite;
      pendAddr <= haddr[7:0];
    end
  end
  // zero wait states, every access answers okay
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  logic cmdWrite;
  logic resRead;
  assign cmdWrite = pendWr && pendAddr == `OFF_CMD;
  assign resRead  = pendRd && pendAddr == `OFF_RESULT;
  // ************************************************************
  // command state
  // ************************************************************
  phase_t      phase;
  logic [7:0]  opcode;
  logic [3:0]  paramIdx;
  logic [3:0]  paramNeed;
  logic [7:0]  params [0:3];
  logic [7:0]  results [0:9];
  logic [3:0]  resIdx;
  logic [3:0]  resCount;
  logic [7:0]  cylinder [0:3];
  logic [7:0]  spec1;
  logic [7:0]  spec2;
  logic [7:0]  configByte;
  logic [7:0]  precompTrack;
  logic [7:0]  perpByte;
  logic        lockBit;
  logic [7:0]  sectorCount;
  logic [7:0]  lastSeekStatus;
  logic        seekPending;
  logic [1:0]  seekDrive;
  logic        doRecal;
  logic [7:0]  seekTarget;
  logic        moveStart;
  logic        moveDone;
  logic [7:0]  intStat;
  logic [7:0]  intMask;
  // parameter byte count per opcode
  function automatic logic [3:0] paramsFor(input logic [7:0] op);
    case (op)
      `CMD_RECAL, `CMD_SENSED, `CMD_PERP: paramsFor = 4'd1;
      `CMD_SPECIFY, `CMD_SEEK:            paramsFor = 4'd2;
      `CMD_CONFIG:                        paramsFor = 4'd3;
      default: begin
        paramsFor = ((op & 8'hBF) == `CMD_RELSEEK) ? 4'd2 : 4'd0;
      end
    endcase
  endfunction : paramsFor
  logic [7:0] byteIn;
  logic [7:0] driveStatus;
  logic [1:0] selDrv;
  logic [7:0] relTarget;
  assign byteIn = hwdata[7:0];
  assign selDrv = params[0][1:0];
  // drive status word: protect, ready, track0, two-sided, head, drive
  assign driveStatus = {1'b0, pinSync[{2'b01, selDrv}], pinSync[{2'b10, selDrv}],
                        pinSync[{2'b00, selDrv}], pinSync[{2'b11, selDrv}],
                        params[0][2], selDrv};
  assign relTarget = opcode[6] ? cylinder[selDrv] + params[1]
                               : cylinder[selDrv] - params[1];
  // ************************************************************
  // phase sequencer
  // ************************************************************
  // bytes written in the wrong phase are dropped, not queued
  always_ff @(posedge clk) begin
    moveStart <= 1'b0;
    if (sys_rst) begin
      phase     <= PH_IDLE;
      opcode    <= 8'h00;
      paramIdx  <= 4'h0;
      paramNeed <= 4'h0;
      resIdx    <= 4'h0;
      resCount  <= 4'h0;
      doRecal   <= 1'b0;
      seekDrive <= 2'b00;
      seekTarget <= 8'h00;
      headSel   <= 1'b0;
      for (int i = 0; i < 10; i++) results[i] <= 8'h00;
      for (int i = 0; i < 4; i++) params[i] <= 8'h00;
    end else begin
      unique case (phase)
        PH_IDLE: begin
          if (cmdWrite) begin
            opcode    <= byteIn;
            paramIdx  <= 4'h0;
            paramNeed <= paramsFor(byteIn);
            if (paramsFor(byteIn) != 4'h0) begin
              phase <= PH_PARAM;
            end else begin
              phase <= PH_EXEC;
            end
          end
        end
        PH_PARAM: begin
          if (cmdWrite) begin
            params[paramIdx[1:0]] <= byteIn;
            paramIdx <= paramIdx + 4'h1;
            if (paramIdx + 4'h1 == paramNeed) phase <= PH_EXEC;
          end
        end
        PH_EXEC: begin
          resIdx   <= 4'h0;
          resCount <= 4'h0;
          phase    <= PH_IDLE;
          if (opcode == `CMD_RECAL) begin
            seekDrive  <= selDrv;
            seekTarget <= 8'h00;
            headSel    <= 1'b0;
            doRecal    <= 1'b1;
            moveStart  <= 1'b1;
          end else if (opcode == `CMD_SEEK) begin
            seekDrive  <= selDrv;
            headSel    <= params[0][2];
            seekTarget <= params[1];
            doRecal    <= 1'b0;
            moveStart  <= 1'b1;
          end else if ((opcode & 8'hBF) == `CMD_RELSEEK) begin
            seekDrive  <= selDrv;
            headSel    <= params[0][2];
            seekTarget <= relTarget;
            doRecal    <= 1'b0;
            moveStart  <= 1'b1;
          end else if (opcode == `CMD_SENSEI) begin
            // without a pending positioning result, answer as invalid
            results[0] <= seekPending ? lastSeekStatus : `VAL_INVALID;
            results[1] <= cylinder[seekDrive];
            resCount   <= seekPending ? 4'd2 : 4'd1;
            phase      <= PH_RESULT;
          end else if (opcode == `CMD_DUMPREG) begin
            for (int i = 0; i < 4; i++) results[i] <= cylinder[i];
            results[4] <= spec1;
            results[5] <= spec2;
            results[6] <= sectorCount;
            results[7] <= {lockBit, perpByte[6:0]};
            results[8] <= configByte;
            results[9] <= precompTrack;
            resCount   <= 4'd10;
            phase      <= PH_RESULT;
          end else if (opcode == `CMD_SENSED) begin
            headSel    <= params[0][2];
            results[0] <= driveStatus;
            resCount   <= 4'd1;
            phase      <= PH_RESULT;
          end else if ((opcode & 8'h7F) == `CMD_LOCK) begin
            results[0] <= {3'b000, opcode[7], 4'h0};
            resCount   <= 4'd1;
            phase      <= PH_RESULT;
          end else if (opcode == `CMD_VERSION) begin
            results[0] <= `VAL_VERSION;
            resCount   <= 4'd1;
            phase      <= PH_RESULT;
          end else if (opcode == `CMD_SPECIFY || opcode == `CMD_CONFIG || opcode == `CMD_PERP) begin
            phase <= PH_IDLE;
          end else begin
            results[0] <= `VAL_INVALID;
            resCount   <= 4'd1;
            phase      <= PH_RESULT;
          end
        end
        PH_RESULT: begin
          if (resRead) begin
            resIdx <= resIdx + 4'h1;
            if (resIdx + 4'h1 == resCount) phase <= PH_IDLE;
          end
        end
        default: phase <= PH_IDLE;
      endcase
    end
  end
  // ************************************************************
  // internal settings written by specify, configure, perp, lock
  // ************************************************************
  // settings hold until rewritten
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spec1        <= `RST_SPEC1;
      spec2        <= `RST_SPEC2;
      configByte   <= `RST_CONFIG;
      precompTrack <= 8'h00;
      perpByte     <= 8'h00;
      lockBit      <= 1'b0;
      sectorCount  <= 8'h00;
    end else if (phase == PH_EXEC) begin
      if (opcode == `CMD_SPECIFY) begin
        spec1 <= params[0];
        spec2 <= params[1];
      end
      if (opcode == `CMD_CONFIG) begin
        configByte   <= params[1];
        precompTrack <= params[2];
      end
      if (opcode == `CMD_PERP && params[0][7]) perpByte <= {1'b0, params[0][6:0]};
      if ((opcode & 8'h7F) == `CMD_LOCK) lockBit <= opcode[7];
    end
  end
  // ************************************************************
  // head motion and cylinder tracking
  // ************************************************************
  logic       stepNow;
  logic       stepOutward;
  head_stepper u_stepper (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (moveStart),
    .recal     (doRecal),
    .fromCyl   (cylinder[seekDrive]),
    .toCyl     (seekTarget),
    .track0    (pinSync[{2'b00, seekDrive}]),
    .stepPulse (stepNow),
    .stepOut   (stepOutward),
    .done      (moveDone)
  );
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) cylinder[i] <= 8'h00;
      lastSeekStatus <= 8'h00;
      seekPending    <= 1'b0;
      stepPulse      <= 1'b0;
      stepDir        <= 1'b0;
      driveSel       <= 2'b00;
    end else begin
      stepPulse <= stepNow;
      stepDir   <= stepOutward;
      if (moveStart) driveSel <= seekDrive;
      if (moveDone) begin
        cylinder[seekDrive] <= doRecal ? 8'h00 : seekTarget;
        lastSeekStatus <= {`VAL_SEEKEND | {3'b000, doRecal && !pinSync[{2'b00, seekDrive}], 4'h0}}
                          | {5'b00000, headSel, seekDrive};
        seekPending    <= 1'b1;
      end else if (phase == PH_EXEC && opcode == `CMD_SENSEI) begin
        seekPending <= 1'b0;
      end
    end
  end
  // ************************************************************
  // interrupts and read data
  // ************************************************************
  function automatic logic resultOp(input logic [7:0] op);
    resultOp = !(op == `CMD_RECAL || op == `CMD_SEEK || op == `CMD_SPECIFY
                 || op == `CMD_CONFIG || op == `CMD_PERP || (op & 8'hBF) == `CMD_RELSEEK);
  endfunction : resultOp
  logic [7:0] intSet;
  assign intSet = {6'b000000, phase == PH_EXEC && resultOp(opcode), moveDone};
  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      intStat <= 8'h00;
      intMask <= 8'h00;
      irq     <= 1'b0;
    end else begin
      intStat <= (intStat & ~((pendWr && pendAddr == `OFF_INTSTAT) ? byteIn : 8'h00)) | intSet;
      if (pendWr && pendAddr == `OFF_INTMASK) intMask <= byteIn;
      irq <= |(intStat & intMask);
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (busTake && !hwrite) begin
      case (haddr[7:0])
        `OFF_RESULT:  hrdata <= {24'h00_0000, (phase == PH_RESULT) ? results[resIdx] : 8'h00};
        `OFF_STATUS:  hrdata <= {24'h00_0000, resCount, 1'b0, phase != PH_IDLE,
                                 phase == PH_RESULT, phase != PH_EXEC};
        `OFF_INTSTAT: hrdata <= {24'h00_0000, intStat};
        `OFF_INTMASK: hrdata <= {24'h00_0000, intMask};
        default:      hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : fdc_head_positioning_commands

// [tb/fdc_pos_monitor.sv]
// Purpose: port checks for the positioning command interpreter
// Assumes: one clock, sync reset high, zero-wait slave
// Notes:   step spacing restarts with each command byte
`timescale 1ns/1ps
`include "fdc_pos_map.svh"
module fdc_pos_monitor (
  input wire logic        clk,       // controller clock
  input wire logic        sys_rst,   // sync reset
  input wire logic        hsel,      // slave select
  input wire logic [31:0] haddr,     // byte address
  input wire logic [1:0]  htrans,    // transfer type
  input wire logic        hwrite,    // write access
  input wire logic        hready,    // bus ready
  input wire logic [31:0] hwdata,    // write data
  input wire logic [31:0] hrdata,    // read data
  input wire logic        hreadyout, // slave ready
  input wire logic        hresp,     // response
  input wire logic [1:0]  driveSel,  // moving drive
  input wire logic        stepPulse, // step strobe
  input wire logic        stepDir,   // outward
  input wire logic        irq        // interrupt
);
  logic        cmdWr; // command byte address phase
  int unsigned gap;   // cycles since last step
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ************************************************************
  // step spacing counter
  // ************************************************************
  // a new command may step at once, so the count restarts full
  assign cmdWr = hsel && hready && htrans[1] && hwrite && haddr == {24'h0, `OFF_CMD};
  always_ff @(posedge clk) begin
    if (sys_rst || cmdWr) gap <= `STEP_CYC;
    else if (stepPulse) gap <= 0;
    else if (gap < `STEP_CYC) gap <= gap + 1;
  end
  // ************************************************************
  // properties
  // ************************************************************
  sequence s_wr(logic [7:0] a, logic [31:0] d);
    hsel && hready && htrans[1] && hwrite && haddr == {24'h0, a} ##1 hwdata == d;
  endsequence
  sequence s_rd(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr == {24'h0, a};
  endsequence
  property p_bus_okay; hreadyout && !hresp; endproperty
  property p_wake; $fell(sys_rst) |-> !irq && !stepPulse && hrdata == 32'h0; endproperty
  property p_step_one; stepPulse |=> !stepPulse; endproperty
  property p_step_gap; stepPulse |-> gap >= `STEP_CYC - 1; endproperty
  property p_step_hold; stepPulse |=> $stable(stepDir) && $stable(driveSel); endproperty
  property p_byte_lane; s_rd(`OFF_RESULT) |=> hrdata[31:8] == 24'h0; endproperty
  property p_unmapped; s_rd(8'h20) |=> hrdata == 32'h0; endproperty
  property p_mask_off; s_wr(`OFF_INTMASK, 32'h0) |-> ##[1:3] !irq; endproperty
  property p_clear; s_wr(`OFF_INTSTAT, 32'h3) |-> ##[1:3] !irq; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("slave not ready or error");
  a_wake: assert property (p_wake) else $error("outputs busy after reset");
  a_step_one: assert property (p_step_one) else $error("step strobe too long");
  a_step_gap: assert property (p_step_gap) else $error("steps too close");
  a_step_hold: assert property (p_step_hold) else $error("direction moved at step");
  a_byte_lane: assert property (p_byte_lane) else $error("result outside low byte");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_mask_off: assert property (p_mask_off) else $error("masked interrupt stays high");
  a_clear: assert property (p_clear) else $error("cleared interrupt stays high");
endmodule : fdc_pos_monitor

// [tb/drive_model.sv]
// Purpose: four drives answering step strobes
// Assumes: one strobe moves one cylinder
// Notes:   the head stop at cylinder 0 swallows outward steps
`timescale 1ns/1ps
module drive_model #(
  parameter logic [7:0] START1 = 8'h03 // drive 1 starts off cylinder 0
) (
  input  wire logic            clk,       // controller clock
  input  wire logic [1:0]      driveSel,  // moving drive
  input  wire logic            stepPulse, // step strobe
  input  wire logic            stepDir,   // high = outward
  output logic      [3:0]      track0Pin, // head at cylinder 0
  output logic      [3:0][7:0] cyl        // head cylinder per drive
);
  initial cyl = {16'h0000, START1, 8'h00};
  // head follows each strobe
  always @(posedge clk) begin
    if (stepPulse && stepDir && cyl[driveSel] != 8'h00) cyl[driveSel] <= cyl[driveSel] - 8'h01;
    else if (stepPulse && !stepDir) cyl[driveSel] <= cyl[driveSel] + 8'h01;
  end
  // track 0 sensor per drive
  always_comb begin
    for (int i = 0; i < 4; i++) track0Pin[i] = (cyl[i] == 8'h00);
  end
endmodule : drive_model

// [tb/tb.sv]
// Purpose: self-checking bench for the positioning command interpreter
// Assumes: zero-wait slave, drive model on the head lines
// Notes:   moves are kept short
`timescale 1ns/1ps
`include "fdc_pos_map.svh"
module tb;
  logic            clk;         // bench clock
  logic            sys_rst;     // sync reset
  logic            hsel;        // slave select
  logic [31:0]     haddr;       // byte address
  logic [1:0]      htrans;      // transfer type
  logic            hwrite;      // write access
  logic [2:0]      hsize;       // transfer size
  wire             hready;      // bus ready
  logic [31:0]     hwdata;      // write data
  logic [31:0]     hrdata;      // read data
  logic            hreadyout;   // slave ready
  logic            hresp;       // response
  logic [3:0]      track0Pin;   // from drives
  logic [3:0]      protectPin;  // write protect
  logic [3:0]      readyPin;    // drive ready
  logic [3:0]      twoSidePin;  // two sided
  logic [1:0]      driveSel;    // moving drive
  logic            stepPulse;   // step strobe
  logic            stepDir;     // outward
  logic            irq;         // interrupt
  logic [3:0][7:0] cyl;         // head positions
  int              failures;    // mismatches
  int              totalChecks; // comparisons
  logic [7:0]      dumpExp [10] = '{0, 0, 8'h06, 0, 8'hA5, 8'h1B, 0, 8'h3C, 8'h4A, 8'h0C};
  logic [7:0]      dumpMsk [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]      ops [3]      = '{8'h1F, `CMD_VERSION, 8'h94};
  logic [7:0]      opsExp [3]   = '{`VAL_INVALID, `VAL_VERSION, 8'h10};
  assign hready = hreadyout;
  fdc_head_positioning_commands DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .track0Pin(track0Pin), .protectPin(protectPin),
    .readyPin(readyPin), .twoSidePin(twoSidePin), .driveSel(driveSel), .headSel(),
    .stepPulse(stepPulse), .stepDir(stepDir), .irq(irq));
  drive_model #(.START1(8'h03)) drives (.clk(clk), .driveSel(driveSel), .stepPulse(stepPulse),
    .stepDir(stepDir), .track0Pin(track0Pin), .cyl(cyl));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ************************************************************
  // bus and compare tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // address phase held until ready, then data phase until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd
  // two idle cycles after the last byte before any result read
  task automatic cmd(input logic [7:0] b [$]);
    foreach (b[i]) wr(`OFF_CMD, {24'h0, b[i]});
    repeat (2) @(posedge clk);
  endtask : cmd
  task automatic res(input string what, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    logic [31:0] v;
    v = 32'h0;
    for (int n = 0; n < 20 && v[`ST_DIO_BIT] !== 1'b1; n++) rd(`OFF_STATUS, v);
    rd(`OFF_RESULT, v);
    check(what, v & {24'h0, m}, {24'h0, e & m});
  endtask : res
  task automatic result_over();
    logic [31:0] v;
    rd(`OFF_STATUS, v);
    check("result pending", {31'h0, v[`ST_DIO_BIT]}, 32'h0);
  endtask : result_over
  // run a move, then one sense interrupt, then clear its event
  task automatic move(input logic [7:0] b [$], input logic [7:0] c, input logic m);
    logic [31:0] v;
    v = 32'h0;
    cmd(b);
    for (int n = 0; n < 3000 && v[`INT_SEEK_BIT] !== 1'b1; n++) rd(`OFF_INTSTAT, v);
    check("irq", {31'h0, irq}, {31'h0, m});
    cmd('{`CMD_SENSEI});
    res("status zero", `VAL_SEEKEND | {6'h0, b[1][1:0]});
    res("cylinder", c);
    check("drive cylinder", {24'h0, cyl[b[1][1:0]]}, {24'h0, c});
    wr(`OFF_INTSTAT, 32'h3);
    repeat (3) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask : move
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    logic [31:0] v;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    protectPin = 4'b0100;
    readyPin = 4'b0100;
    twoSidePin = 4'b0100;
    failures = 0;
    totalChecks = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`OFF_INTSTAT, v);
    check("intstat", v, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, v);
    check("unmapped", v, 32'h0);
    cmd('{`CMD_SENSEI});
    res("nothing finished", `VAL_INVALID);
    result_over();
    $display("idle test done");
    wr(`OFF_INTMASK, 32'h0);
    move('{`CMD_RECAL, 8'h01}, 8'h00, 1'b0);
    wr(`OFF_INTMASK, 32'h1);
    move('{`CMD_SEEK, 8'h02, 8'h05}, 8'h05, 1'b1);
    move('{8'hCF, 8'h02, 8'h03}, 8'h08, 1'b1);
    move('{`CMD_RELSEEK, 8'h02, 8'h02}, 8'h06, 1'b1);
    $display("move test done");
    cmd('{`CMD_SPECIFY, 8'hA5, 8'h1B});
    cmd('{`CMD_CONFIG, 8'h00, 8'h4A, 8'h0C});
    cmd('{`CMD_PERP, 8'hBC});
    cmd('{`CMD_DUMPREG});
    for (int i = 0; i < 10; i++) res("dump byte", dumpExp[i], dumpMsk[i]);
    result_over();
    $display("dump test done");
    for (int i = 0; i < 3; i++) begin
      cmd('{ops[i]});
      res("single byte", opsExp[i]);
      result_over();
    end
    $display("single byte test done");
    cmd('{`CMD_SENSED, 8'h06});
    res("drive status", 8'h6E);
    result_over();
    $display("drive status test done");
    report_and_stop();
  end
  // watchdog far beyond what the moves need
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule : tb
bind fdc_head_positioning_commands fdc_pos_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .driveSel(driveSel), .stepPulse(stepPulse), .stepDir(stepDir),
  .irq(irq));
